/* design/sar_adc_pkg.sv */
`default_nettype none
package sar_adc_pkg;

  // Converter geometry.
  localparam int RESULT_BITS     = 10;
  localparam int BYTE_BITS       = 8;
  localparam int CHANNEL_BITS    = 2;
  localparam int CLKSEL_BITS     = 3;
  localparam int TAD_COUNT_BITS  = 4;
  localparam int DIV_COUNT_BITS  = 6;

  // System clock rate.
  localparam int CLOCK_PERIOD_NS = 10;

  // Conversion timing in bit conversion periods.
  localparam logic [3:0] CONV_LAST_TAD   = 4'hA;  // Eleven periods, numbered 0 to 10.
  localparam logic [3:0] ABORT_LAST_TAD  = 4'h1;  // Two periods, numbered 0 and 1.

  // Conversion clock select codes.
  localparam logic [2:0] CLKSEL_DIV2  = 3'h0;
  localparam logic [2:0] CLKSEL_DIV4  = 3'h4;
  localparam logic [2:0] CLKSEL_DIV8  = 3'h1;
  localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
  localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
  localparam logic [1:0] CLKSEL_OSC_LOW = 2'h3;  // Low two bits set pick the dedicated oscillator.

  // Result layout.
  localparam logic [RESULT_BITS-1:0] SAR_FIRST_TRIAL = 10'h200;
  localparam logic [BYTE_BITS-1:0]   RESULT_RESET    = 8'h00;
  localparam logic [5:0]             RESERVED_ZERO   = 6'h00;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_DELAY   = 2'b01,
    ST_CONVERT = 2'b10,
    ST_ABORT   = 2'b11
  } convState_t;

endpackage
`default_nettype wire

/* design/tad_clock_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module tad_clock_divider (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst,
  // Selection and alignment.
  input  wire logic [2:0] clockSelect,
  input  wire logic       restart,
  // Dedicated oscillator pin.
  input  wire logic       oscPin,
  // One-cycle bit period enable.
  output logic            tadTick
);

  typedef struct packed {
    logic [5:0] count;
    logic       osc1;
    logic       osc2;
    logic       osc3;
    logic       oscLevel;
    logic       tick;
  } divState_t;

  divState_t s;
  divState_t n;
  logic [2:0] expo;
  logic [5:0] lastCount;
  logic       oscSelected;

  // Divide ratio is two to the power expo; the select code packs expo minus one as low bits times two plus bit 2.
  always_comb
  begin
    n = s;
    n.tick = 1'b0;
    oscSelected = (clockSelect[1:0] == sar_adc_pkg::CLKSEL_OSC_LOW);
    expo = {clockSelect[1:0], 1'b0} + {2'b00, clockSelect[2]} + 3'h1;
    lastCount = 6'((7'h01 << expo) - 7'h01);
    n.osc1 = oscPin;
    n.osc2 = s.osc1;
    n.osc3 = s.osc2;
    // The oscillator level only moves once the second and third stages agree.
    if (s.osc2 == s.osc3)
    begin
      n.oscLevel = s.osc3;
    end
    if (oscSelected)
    begin
      n.tick = (s.osc2 == s.osc3) && s.osc3 && !s.oscLevel;
    end
    else if (restart)
    begin
      n.count = 6'h00;
    end
    else if (s.count >= lastCount)
    begin
      n.count = 6'h00;
      n.tick  = 1'b1;
    end
    else
    begin
      n.count = s.count + 6'h01;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign tadTick = s.tick;

endmodule
`default_nettype wire

/* design/sar_adc_control.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control #(
  parameter int RESULT_BITS = sar_adc_pkg::RESULT_BITS
) (
  // Clock and reset.
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Control bits held by software.
  input  wire logic                   converterEnable,
  input  wire logic                   resultFormat,
  input  wire logic                   referenceSelect,
  input  wire logic [1:0]             channelSelect,
  input  wire logic [2:0]             convClockSelect,
  // Go/done and flag writes from software.
  input  wire logic                   goWrite,
  input  wire logic                   goWriteValue,
  input  wire logic                   flagClear,
  // Core status.
  input  wire logic                   irqEnable,
  input  wire logic                   globalIrqEnable,
  input  wire logic                   sleepActive,
  input  wire logic                   instrTick,
  // Capture/compare unit.
  input  wire logic                   specialTrigger,
  // Analog front end.
  input  wire logic                   comparatorPin,
  input  wire logic                   oscPin,
  // Results and status.
  output logic [7:0]                  resultHigh,
  output logic [7:0]                  resultLow,
  output logic                        goDone,
  output logic                        completeFlag,
  output logic                        wakeRequest,
  output logic                        vectorRequest,
  output logic                        timerReset,
  // Analog controls.
  output logic [RESULT_BITS-1:0]      dacCode,
  output logic                        sampleHold,
  output logic                        analogPowered,
  output logic                        refExternal,
  output logic [1:0]                  channelOut
);

  typedef struct packed {
    sar_adc_pkg::convState_t  state;
    logic [3:0]               tadCount;
    logic [RESULT_BITS-1:0]   sar;
    logic                     go;
    logic                     flag;
    logic [7:0]               high;
    logic [7:0]               low;
    logic                     sleepOff;
    logic                     wake;
    logic                     vector;
    logic                     timerClr;
    logic                     sample;
    logic                     powered;
    logic                     refExt;
    logic [1:0]               channel;
  } ctlState_t;

  ctlState_t s;
  ctlState_t n;

  logic tadTick;
  logic restartTad;
  logic oscSelected;
  logic startReq;
  logic busy;
  logic swAbort;
  logic sleepAbort;
  logic doneNow;
  logic [3:0] bitIndex;

  // The divider runs from the system clock, so on the divided selects the bit period scales with its rate.
  tad_clock_divider u_divider (
    .clock       (clock),
    .rst         (rst),
    .clockSelect (convClockSelect),
    .restart     (restartTad),
    .oscPin      (oscPin),
    .tadTick     (tadTick)
  );

  // Request decode shared by the sequencer and the checks.
  always_comb
  begin
    oscSelected = (convClockSelect[1:0] == sar_adc_pkg::CLKSEL_OSC_LOW);
    busy        = (s.state == sar_adc_pkg::ST_DELAY) || (s.state == sar_adc_pkg::ST_CONVERT);
    startReq    = converterEnable && !busy && (s.state != sar_adc_pkg::ST_ABORT) &&
                  ((goWrite && goWriteValue) || specialTrigger);
    swAbort     = busy && goWrite && !goWriteValue;
    sleepAbort  = busy && sleepActive && !oscSelected;
    doneNow     = (s.state == sar_adc_pkg::ST_CONVERT) && tadTick &&
                  (s.tadCount == sar_adc_pkg::CONV_LAST_TAD) && !swAbort && !sleepAbort;
    bitIndex    = 4'(sar_adc_pkg::CONV_LAST_TAD - s.tadCount);
  end

  // Sequencer; all pulses drop by default so they stand one cycle.
  always_comb
  begin
    n = s;
    restartTad = 1'b0;
    n.timerClr = specialTrigger;
    n.refExt   = referenceSelect;
    n.channel  = channelSelect;
    unique case (s.state)
      sar_adc_pkg::ST_IDLE:
      begin
        if (startReq)
        begin
          n.go       = 1'b1;
          n.tadCount = 4'h0;
          restartTad = 1'b1;
          // The extra wait lets a sleep instruction run before the noisy conversion.
          n.state    = oscSelected ? sar_adc_pkg::ST_DELAY : sar_adc_pkg::ST_CONVERT;
          n.sar      = sar_adc_pkg::SAR_FIRST_TRIAL;
          n.sample   = 1'b0;
        end
      end
      sar_adc_pkg::ST_DELAY:
      begin
        if (instrTick)
        begin
          n.state = sar_adc_pkg::ST_CONVERT;
        end
      end
      sar_adc_pkg::ST_CONVERT:
      begin
        // Period 0 settles the hold; periods 1 to 10 decide one bit each.
        // The comparator is strobed by this clock inside the converter, so it is read directly.
        // A three-stage synchroniser here would hand back the verdict on an older trial at the fast divides.
        if (tadTick && s.tadCount != 4'h0)
        begin
          n.sar[bitIndex] = comparatorPin;
          if (bitIndex != 4'h0)
          begin
            n.sar[bitIndex - 4'h1] = 1'b1;
          end
        end
        if (tadTick)
        begin
          n.tadCount = s.tadCount + 4'h1;
        end
        if (doneNow)
        begin
          n.go     = 1'b0;
          n.state  = sar_adc_pkg::ST_IDLE;
          n.sample = 1'b1;
          // Both bytes load from one value in one cycle, so no torn read is possible.
          if (resultFormat)
          begin
            n.high = {sar_adc_pkg::RESERVED_ZERO, n.sar[9:8]};
            n.low  = n.sar[7:0];
          end
          else
          begin
            n.high = n.sar[9:2];
            n.low  = {n.sar[1:0], sar_adc_pkg::RESERVED_ZERO};
          end
          if (sleepActive && oscSelected && !irqEnable)
          begin
            n.sleepOff = 1'b1;
          end
        end
      end
      sar_adc_pkg::ST_ABORT:
      begin
        if (tadTick)
        begin
          n.tadCount = s.tadCount + 4'h1;
          if (s.tadCount == sar_adc_pkg::ABORT_LAST_TAD)
          begin
            n.state  = sar_adc_pkg::ST_IDLE;
            n.sample = 1'b1;
          end
        end
      end
    endcase
    // An abort leaves the result bytes alone and starts the two-period recovery.
    if (swAbort || sleepAbort)
    begin
      n.state    = sar_adc_pkg::ST_ABORT;
      n.go       = 1'b0;
      n.tadCount = 4'h0;
      n.sample   = 1'b0;
      restartTad = 1'b1;
    end
    if (sleepAbort)
    begin
      n.sleepOff = 1'b1;
    end
    if (!sleepActive)
    begin
      n.sleepOff = 1'b0;
    end
    // Turning the converter off ends any conversion at once.
    if (!converterEnable)
    begin
      n.state  = sar_adc_pkg::ST_IDLE;
      n.go     = 1'b0;
      n.sample = 1'b0;
    end
    else if (n.state == sar_adc_pkg::ST_IDLE)
    begin
      n.sample = !n.sleepOff;
    end
    n.powered = converterEnable && !n.sleepOff;
    // The set wins over a clear arriving in the same cycle.
    n.flag   = (s.flag && !flagClear) || doneNow;
    n.wake   = n.flag && irqEnable;
    n.vector = n.flag && irqEnable && globalIrqEnable;
  end

  // Reset clears everything, which leaves the converter off and idle.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign resultHigh    = s.high;
  assign resultLow     = s.low;
  assign goDone        = s.go;
  assign completeFlag  = s.flag;
  assign wakeRequest   = s.wake;
  assign vectorRequest = s.vector;
  assign timerReset    = s.timerClr;
  assign dacCode       = s.sar;
  assign sampleHold    = s.sample;
  assign analogPowered = s.powered;
  assign refExternal   = s.refExt;
  assign channelOut    = s.channel;

  // Checks run on the system clock and stand down during reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence seqSwStart;
    (s.state == sar_adc_pkg::ST_IDLE) && converterEnable && goWrite && goWriteValue && !oscSelected;
  endsequence

  sequence seqAbortEntry;
    busy && (swAbort || sleepAbort) && converterEnable;
  endsequence

  AST_START: assert property (seqSwStart |=> (s.state == sar_adc_pkg::ST_CONVERT) && s.go)
    else $error("Start request did not begin a conversion.");

  AST_FRC_DELAY: assert property (
    ((s.state == sar_adc_pkg::ST_IDLE) && converterEnable && goWrite && goWriteValue && oscSelected)
    |=> (s.state == sar_adc_pkg::ST_DELAY))
    else $error("Oscillator start skipped the instruction wait.");

  AST_FLAG_SET: assert property (doneNow |=> completeFlag && !goDone)
    else $error("Completion did not set the flag and clear go.");

  AST_CONV_LEN: assert property (
    (s.state == sar_adc_pkg::ST_CONVERT) && (s.tadCount != sar_adc_pkg::CONV_LAST_TAD) && converterEnable
    && !swAbort && !sleepAbort |=> (s.state == sar_adc_pkg::ST_CONVERT) && goDone)
    else $error("Conversion ended before its eleventh period.");

  AST_RESULT_HOLD: assert property (seqAbortEntry |=> $stable(resultHigh) && $stable(resultLow) && !goDone)
    else $error("Abort disturbed the result bytes.");

  AST_ABORT_WAIT: assert property (
    (s.state == sar_adc_pkg::ST_ABORT) && tadTick && (s.tadCount == 4'h1) && converterEnable
    |=> (s.state == sar_adc_pkg::ST_IDLE) && sampleHold == !s.sleepOff)
    else $error("Abort recovery did not return to acquisition after two periods.");

  AST_JUSTIFY: assert property (doneNow && resultFormat |=> (resultHigh[7:2] == 6'h00)
    && ({resultHigh[1:0], resultLow} == dacCode))
    else $error("Right justified layout wrong.");

  AST_BOTH: assert property (doneNow && !resultFormat |=> ({resultHigh, resultLow[7:6]} == dacCode)
    && (resultLow[5:0] == 6'h00))
    else $error("Result bytes were not loaded together.");

  AST_SLEEP_ABORT: assert property (sleepAbort && converterEnable
    |=> (s.state == sar_adc_pkg::ST_ABORT) && !analogPowered)
    else $error("Sleep on a divided clock did not abort and power down.");

  AST_WAKE: assert property (completeFlag && irqEnable && !flagClear |=> wakeRequest)
    else $error("Flag with enable did not raise the wake request.");

  AST_FLAG_HOLD: assert property (completeFlag && !flagClear |=> completeFlag)
    else $error("Hardware cleared the completion flag.");

  AST_TRIGGER: assert property (specialTrigger |=> timerReset)
    else $error("Special trigger did not reset the timer.");

  AST_OFF: assert property (!converterEnable |=> (s.state == sar_adc_pkg::ST_IDLE) && !goDone)
    else $error("Disabled converter kept converting.");

  // Sleeping on the oscillator with the interrupt off powers down once the result is in.
  AST_SLEEP_OFF: assert property (doneNow && sleepActive && oscSelected && !irqEnable && converterEnable
    |=> !analogPowered && completeFlag)
    else $error("Oscillator sleep did not power down after completion.");

  AST_VECTOR: assert property (
    completeFlag && irqEnable && globalIrqEnable && !flagClear |=> vectorRequest)
    else $error("Flag with both enables did not raise the vector request.");

  AST_NO_WAKE: assert property (!irqEnable |=> !wakeRequest && !vectorRequest)
    else $error("Wake raised with the interrupt disabled.");

  AST_TRIG_START: assert property (
    specialTrigger && converterEnable && (s.state == sar_adc_pkg::ST_IDLE) |=> goDone)
    else $error("Special trigger did not set go/done.");

  AST_OSC_WAIT: assert property (
    (s.state == sar_adc_pkg::ST_DELAY) && !instrTick && converterEnable && !swAbort && !sleepAbort
    |=> (s.state == sar_adc_pkg::ST_DELAY))
    else $error("Oscillator start did not wait for an instruction cycle.");

  AST_REF_COPY: assert property (1'b1 |=> (refExternal == $past(referenceSelect))
    && (channelOut == $past(channelSelect)))
    else $error("Reference or channel select not passed to the analog side.");

endmodule
`default_nettype wire

/* test/analog_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  // Input levels, four channels of ten bits against the supply.
  input  wire logic [39:0] levels,
  // Controls from the converter.
  input  wire logic [9:0]  dacCode,
  input  wire logic [1:0]  channelOut,
  input  wire logic        refExternal,
  input  wire logic        sampleHold,
  input  wire logic        analogPowered,
  // Comparator and dedicated oscillator.
  output logic             comparatorPin,
  output logic             oscPin
);
  logic [9:0] held = 10'h000;

  // The hold capacitor tracks while acquiring and freezes during conversion.
  // The external reference is modelled as twice the supply, halving the code.
  always @(sampleHold or levels or channelOut or refExternal)
    if (sampleHold)
      held = refExternal ? levels[channelOut*10 +: 10] >> 1 : levels[channelOut*10 +: 10];

  // An unpowered comparator gives no useful answer, so it reads low.
  assign comparatorPin = analogPowered ? (held >= dacCode) : 1'b0;

  // Free-running oscillator, unrelated in phase to the system clock.
  initial oscPin = 1'b0;
  always #37.3 oscPin = ~oscPin;
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t %s", $time, m); end end
module tb;
  typedef struct {logic [2:0] sel; logic fmt; logic [1:0] ch; logic refSel; logic irq; logic gie; int div;} row_t;
  logic        clock, rst, converterEnable, resultFormat, referenceSelect, goWrite, goWriteValue;
  logic        flagClear, irqEnable, globalIrqEnable, sleepActive, instrTick, specialTrigger, tickOn;
  logic        comparatorPin, oscPin, goDone, completeFlag, wakeRequest, vectorRequest, timerReset;
  logic        sampleHold, analogPowered, refExternal;
  logic [1:0]  channelSelect, channelOut;
  logic [2:0]  convClockSelect;
  logic [7:0]  resultHigh, resultLow;
  logic [9:0]  dacCode;
  logic [15:0] prev;
  logic [39:0] levels = {10'h3FF, 10'h155, 10'h201, 10'h0A3};
  int          n_mismatch = 0, n_tests = 0, cyc, tc = 0;
  row_t        rows[8] = '{'{3'h0, 1, 0, 0, 1, 1, 2}, '{3'h4, 0, 1, 0, 1, 0, 4}, '{3'h1, 1, 2, 1, 0, 0, 8},
                           '{3'h5, 0, 3, 0, 0, 1, 16}, '{3'h2, 1, 3, 1, 1, 1, 32}, '{3'h6, 0, 2, 0, 1, 0, 64},
                           '{3'h3, 1, 1, 1, 0, 0, 0}, '{3'h7, 0, 0, 0, 1, 1, 0}};

  sar_adc_control dut (.clock(clock), .rst(rst), .converterEnable(converterEnable), .resultFormat(resultFormat),
    .referenceSelect(referenceSelect), .channelSelect(channelSelect), .convClockSelect(convClockSelect),
    .goWrite(goWrite), .goWriteValue(goWriteValue), .flagClear(flagClear), .irqEnable(irqEnable),
    .globalIrqEnable(globalIrqEnable), .sleepActive(sleepActive), .instrTick(instrTick),
    .specialTrigger(specialTrigger), .comparatorPin(comparatorPin), .oscPin(oscPin), .resultHigh(resultHigh),
    .resultLow(resultLow), .goDone(goDone), .completeFlag(completeFlag), .wakeRequest(wakeRequest),
    .vectorRequest(vectorRequest), .timerReset(timerReset), .dacCode(dacCode), .sampleHold(sampleHold),
    .analogPowered(analogPowered), .refExternal(refExternal), .channelOut(channelOut));

  analog_front_model afe (.levels(levels), .dacCode(dacCode), .channelOut(channelOut), .refExternal(refExternal),
    .sampleHold(sampleHold), .analogPowered(analogPowered), .comparatorPin(comparatorPin), .oscPin(oscPin));

  // System clock of 100 MHz.
  initial clock = 1'b0;
  always #5 clock = ~clock;

  // One instruction cycle every four system clocks; it can be held off.
  always @(posedge clock)
  begin
    tc <= tc + 1;
    instrTick <= tickOn && (tc[1:0] == 2'h3);
  end

  // Expected placement of a code across the two result bytes.
  function automatic logic [15:0] pack(logic [9:0] r, logic fmt);
    return fmt ? {6'h00, r} : {r, 6'h00};
  endfunction

  // Expected code for a channel; the external reference halves it.
  function automatic logic [9:0] expCode(logic [1:0] ch, logic refSel);
    logic [9:0] l;
    l = levels[ch*10 +: 10];
    return refSel ? l >> 1 : l;
  endfunction

  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Software write of go/done; outputs are looked at just after the taking edge.
  task automatic goPulse(logic v);
    @(posedge clock);
    goWrite <= 1'b1;
    goWriteValue <= v;
    @(posedge clock);
    goWrite <= 1'b0;
    #1;
  endtask

  task automatic clearFlag();
    @(posedge clock);
    flagClear <= 1'b1;
    @(posedge clock);
    flagClear <= 1'b0;
    #1;
    `CHK(completeFlag, 1'b0, "flag not cleared")
  endtask

  // Bounded wait for go/done to fall; a hang ends the run.
  task automatic waitIdle(int bound);
    cyc = 0;
    while (goDone !== 1'b0 && cyc < bound)
    begin
      tick(1);
      cyc++;
    end
    if (cyc >= bound)
    begin
      n_mismatch++;
      $display("[ERR] %0t hang waiting for completion", $time);
      give_verdict();
    end
  endtask

  // Main sequence: table of conversions, then the awkward cases.
  initial
  begin
    {rst, converterEnable, resultFormat, referenceSelect, goWrite, goWriteValue, flagClear} = 7'h01 << 6;
    {irqEnable, globalIrqEnable, sleepActive, specialTrigger, tickOn} = 5'h01;
    channelSelect = 2'h0;
    convClockSelect = 3'h0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK({resultHigh, resultLow, goDone, completeFlag, analogPowered}, 19'h00000, "reset state")
    @(posedge clock) converterEnable <= 1'b1;
    tick(4);
    foreach (rows[i])
    begin
      @(posedge clock);
      convClockSelect <= rows[i].sel;
      resultFormat <= rows[i].fmt;
      channelSelect <= rows[i].ch;
      referenceSelect <= rows[i].refSel;
      irqEnable <= rows[i].irq;
      globalIrqEnable <= rows[i].gie;
      tick(40);
      goPulse(1'b1);
      `CHK(goDone, 1'b1, "go not set")
      `CHK(dacCode, 10'h200, "first trial code")
      `CHK({refExternal, channelOut}, {rows[i].refSel, rows[i].ch}, "reference or channel")
      waitIdle(rows[i].div ? 11 * rows[i].div + 8 : 400);
      if (rows[i].div) `CHK(cyc >= 11 * rows[i].div, 1'b1, "conversion too short")
      `CHK({resultHigh, resultLow}, pack(expCode(rows[i].ch, rows[i].refSel), rows[i].fmt), "result")
      `CHK(completeFlag, 1'b1, "flag not set")
      tick(1);
      `CHK({wakeRequest, vectorRequest}, {rows[i].irq, rows[i].irq & rows[i].gie}, "wake")
      clearFlag();
    end
    // Start refused while the converter is off.
    @(posedge clock) converterEnable <= 1'b0;
    goPulse(1'b1);
    `CHK(goDone, 1'b0, "start while off")
    @(posedge clock);
    {converterEnable, convClockSelect, resultFormat, channelSelect, referenceSelect} <= {1'b1, 3'h0, 1'b1, 2'h0, 1'b0};
    tick(40);
    // Hardware trigger sets go/done and pulses the timer reset once.
    @(posedge clock) specialTrigger <= 1'b1;
    @(posedge clock) specialTrigger <= 1'b0;
    #1;
    `CHK({goDone, timerReset}, 2'b11, "trigger start")
    tick(1);
    `CHK(timerReset, 1'b0, "timer reset too long")
    waitIdle(40);
    `CHK({resultHigh, resultLow}, pack(10'h0A3, 1'b1), "trigger result")
    clearFlag();
    // Abort keeps the old result and waits two periods before acquiring.
    @(posedge clock) convClockSelect <= 3'h6;
    prev = {resultHigh, resultLow};
    goPulse(1'b1);
    tick(100);
    goPulse(1'b0);
    `CHK({goDone, sampleHold, resultHigh, resultLow}, {2'b00, prev}, "abort")
    cyc = 0;
    while (sampleHold !== 1'b1 && cyc < 200)
    begin
      tick(1);
      cyc++;
    end
    `CHK(cyc >= 118 && cyc <= 136, 1'b1, "abort recovery time")
    tick(800);
    `CHK({completeFlag, resultHigh, resultLow}, {1'b0, prev}, "result after abort")
    // Oscillator start waits for an instruction cycle.
    @(posedge clock) {convClockSelect, tickOn, irqEnable} <= {3'h3, 1'b0, 1'b0};
    goPulse(1'b1);
    tick(300);
    `CHK({goDone, completeFlag}, 2'b10, "started without instruction")
    @(posedge clock) tickOn <= 1'b1;
    waitIdle(400);
    `CHK(completeFlag, 1'b1, "oscillator completion")
    clearFlag();
    // Sleep on the oscillator with interrupt off powers down after completion.
    goPulse(1'b1);
    @(posedge clock) sleepActive <= 1'b1;
    waitIdle(400);
    tick(2);
    `CHK({analogPowered, completeFlag}, 2'b01, "sleep on oscillator")
    @(posedge clock) sleepActive <= 1'b0;
    tick(2);
    `CHK(analogPowered, 1'b1, "power back")
    clearFlag();
    // Sleep on a divided clock aborts and powers down.
    @(posedge clock) convClockSelect <= 3'h6;
    goPulse(1'b1);
    tick(50);
    @(posedge clock) sleepActive <= 1'b1;
    tick(1);
    `CHK({goDone, analogPowered}, 2'b00, "sleep abort")
    @(posedge clock) sleepActive <= 1'b0;
    tick(300);
    // Reset in mid-conversion clears everything.
    goPulse(1'b1);
    tick(20);
    @(posedge clock) rst <= 1'b1;
    #1;
    `CHK({resultHigh, resultLow, goDone, completeFlag, analogPowered}, 19'h00000, "reset mid-run")
    tick(2);
    give_verdict();
  end
endmodule
`default_nettype wire
